// [pfc_channel.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defines.svh"
module pfc_channel (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	pfc_cmp_if.ch cmp
);
	import pfc_pkg::*;
	logic wave_q, wave_d;

	always_comb begin
		wave_d = wave_q;
		if (cmp.running && cmp.tick && cmp.match) begin
			unique case (cmp.out_mode)
				`PFC_OM_NONINV: wave_d = !cmp.up;
				`PFC_OM_INV: wave_d = cmp.up;
				`PFC_OM_TOGGLE: wave_d = cmp.toggle_ok ? !wave_q : wave_q;
				`PFC_OM_OFF: wave_d = wave_q;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			wave_q <= 1'b0;
		end else begin
			wave_q <= wave_d;
		end
	end

	// A value above top never equals the count, so no match ever fires.
	assign cmp.match = (cmp.count == cmp.compare);
	assign cmp.wave = wave_q;
endmodule : pfc_channel
`default_nettype wire

// [pfc_cmp_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface pfc_cmp_if;
	import pfc_pkg::*;
	pfc_word_t count;
	pfc_word_t compare;
	logic up;
	logic tick;
	logic running;
	logic [1:0] out_mode;
	logic toggle_ok;
	logic at_bottom;
	logic match;
	logic wave;
	modport ctr (output count, compare, up, tick, running, out_mode, toggle_ok, at_bottom,
		input match, wave);
	modport ch (input count, compare, up, tick, running, out_mode, toggle_ok, at_bottom,
		output match, wave);
endinterface : pfc_cmp_if
`default_nettype wire

// [pfc_defines.svh]
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH

`define PFC_ADDR_CTRL 4'h0
`define PFC_ADDR_PRESCALE 4'h1
`define PFC_ADDR_CMP_A 4'h2
`define PFC_ADDR_CMP_B 4'h3
`define PFC_ADDR_CAP_TOP 4'h4
`define PFC_ADDR_COUNT 4'h5
`define PFC_ADDR_FLAGS 4'h6
`define PFC_ADDR_ACT_A 4'h7
`define PFC_ADDR_ACT_B 4'h8

`define PFC_CTRL_MODE_LSB 0
`define PFC_CTRL_OMA_LSB 4
`define PFC_CTRL_OMB_LSB 6
`define PFC_CTRL_ROUTE_A 8
`define PFC_CTRL_ROUTE_B 9
`define PFC_CTRL_DIR_A 10
`define PFC_CTRL_DIR_B 11

`define PFC_MODE_ICR_TOP 4'h8
`define PFC_MODE_OCRA_TOP 4'h9
`define PFC_MODE_TOP_BIT 3

`define PFC_OM_OFF 2'h0
`define PFC_OM_TOGGLE 2'h1
`define PFC_OM_NONINV 2'h2
`define PFC_OM_INV 2'h3

`define PFC_FLAG_OVF 0
`define PFC_FLAG_MA 1
`define PFC_FLAG_MB 2
`define PFC_FLAG_CAP 3

`define PFC_PS_STOP 3'h0
`define PFC_PS_DIV1 3'h1
`define PFC_PS_DIV8 3'h2
`define PFC_PS_DIV64 3'h3
`define PFC_PS_DIV256 3'h4
`define PFC_PS_DIV1024 3'h5
`define PFC_DIV8_LAST 10'h007
`define PFC_DIV64_LAST 10'h03F
`define PFC_DIV256_LAST 10'h0FF
`define PFC_DIV1024_LAST 10'h3FF

`define PFC_MIN_TOP 16'h0003

`endif

// [pfc_load_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pfc_load_model (
	input wire logic sys_clk_i,
	input wire logic wave_i,
	input wire logic oe_n_i,
	output int high_count_o
);
	// A pin that is not driven is pulled low by the load.
	initial high_count_o = 0;
	always @(posedge sys_clk_i) high_count_o <= high_count_o + int'(!oe_n_i && wave_i);
endmodule : pfc_load_model
`default_nettype wire

// [pfc_pkg.sv]
package pfc_pkg;
	typedef enum logic {PFC_UP, PFC_DOWN} pfc_dir_t;
	typedef logic [15:0] pfc_word_t;
endpackage : pfc_pkg

// [pfc_pwm.sv]
// Behaviour
// - Selector 8 or 9 enables this mode
// - Count zero up to top, then down
// - Non-inverting clears on up match, sets down
// - Output mode two normal, three inverted
// - Top from capture (8) or compare A (9)
// - Reverse at top on next tick, no hold
// - Top from 0x0003 to full 16 bits
// - Compares load at zero with overflow flag
// - Top-source flag set when top reached
// - Match flag when count equals compare
// - Compare above top never matches
// - Pin needs direction and route enable
// - Zero compare low, top compare high if non-inverting
// - Prescale 1, 8, 64, 256, 1024
// - Synchronous; tick is only an enable
// - Buffer load timing shifted to zero
// - Mode one toggles A when selector bit3
// - Mode zero leaves pin to port
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defines.svh"
module pfc_pwm (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic port_out_a_i,
	input wire logic port_out_b_i,
	output logic wave_out_a_o,
	output logic wave_out_b_o,
	output logic pin_oe_n_a_o,
	output logic pin_oe_n_b_o,
	output logic [3:0] flags_o
);
	import pfc_pkg::*;

	logic [11:0] ctrl_q, ctrl_d;
	logic [2:0] ps_q, ps_d;
	pfc_word_t buf_a_q, buf_a_d, buf_b_q, buf_b_d, cap_q, cap_d;
	pfc_word_t act_a_q, act_a_d, act_b_q, act_b_d;
	pfc_word_t cnt_q, cnt_d;
	pfc_dir_t dir_q, dir_d;
	logic [9:0] pre_q, pre_d;
	logic [3:0] flag_q, flag_d;
	logic [15:0] rdata_q, rdata_d;

	logic [3:0] mode;
	logic [1:0] om_a, om_b;
	logic running, tick, at_top, at_bottom;
	pfc_word_t top;
	logic [9:0] pre_last;
	logic [3:0] flag_set;

	pfc_cmp_if cmp_a ();
	pfc_cmp_if cmp_b ();

	function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] target);
		addr_hit = (a == target);
	endfunction : addr_hit

	assign mode = ctrl_q[`PFC_CTRL_MODE_LSB +: 4];
	assign om_a = ctrl_q[`PFC_CTRL_OMA_LSB +: 2];
	assign om_b = ctrl_q[`PFC_CTRL_OMB_LSB +: 2];
	assign running = (mode == `PFC_MODE_ICR_TOP) || (mode == `PFC_MODE_OCRA_TOP);
	assign top = (mode == `PFC_MODE_ICR_TOP) ? cap_q : act_a_q;
	assign at_top = (cnt_q == top);
	assign at_bottom = (cnt_q == 16'h0000);

	// Prescaler: the tick is a one-cycle enable, never a clock.
	always_comb begin
		unique case (ps_q)
			`PFC_PS_DIV8: pre_last = `PFC_DIV8_LAST;
			`PFC_PS_DIV64: pre_last = `PFC_DIV64_LAST;
			`PFC_PS_DIV256: pre_last = `PFC_DIV256_LAST;
			`PFC_PS_DIV1024: pre_last = `PFC_DIV1024_LAST;
			default: pre_last = 10'h000;
		endcase
		pre_d = pre_q;
		tick = 1'b0;
		if (ps_q == `PFC_PS_STOP || ps_q > `PFC_PS_DIV1024 || !running) begin
			pre_d = 10'h000;
		end else if (pre_q >= pre_last) begin
			pre_d = 10'h000;
			tick = 1'b1;
		end else begin
			pre_d = pre_q + 10'h001;
		end
	end

	// Counter and double-buffered compare registers.
	always_comb begin
		cnt_d = cnt_q;
		dir_d = dir_q;
		act_a_d = act_a_q;
		act_b_d = act_b_q;
		flag_set = 4'h0;
		if (running && tick) begin
			if (dir_q == PFC_UP) begin
				if (at_top) begin
					dir_d = PFC_DOWN;
					if (cnt_q != 16'h0000) begin
						cnt_d = cnt_q - 16'h0001;
					end
				end else begin
					cnt_d = cnt_q + 16'h0001;
				end
			end else begin
				if (at_bottom) begin
					dir_d = PFC_UP;
					cnt_d = 16'h0001;
				end else begin
					cnt_d = cnt_q - 16'h0001;
				end
			end
			if (at_bottom) begin
				act_a_d = buf_a_q;
				act_b_d = buf_b_q;
				flag_set[`PFC_FLAG_OVF] = 1'b1;
			end
			if (at_top) begin
				if (mode == `PFC_MODE_ICR_TOP) begin
					flag_set[`PFC_FLAG_CAP] = 1'b1;
				end else begin
					flag_set[`PFC_FLAG_MA] = 1'b1;
				end
			end
			flag_set[`PFC_FLAG_MA] = flag_set[`PFC_FLAG_MA] | cmp_a.match;
			flag_set[`PFC_FLAG_MB] = flag_set[`PFC_FLAG_MB] | cmp_b.match;
		end
	end

	// Register port: writes steer the block, reads show its state.
	always_comb begin
		ctrl_d = ctrl_q;
		ps_d = ps_q;
		buf_a_d = buf_a_q;
		buf_b_d = buf_b_q;
		cap_d = cap_q;
		flag_d = flag_q | flag_set;
		rdata_d = 16'h0000;
		if (reg_wr_i) begin
			if (addr_hit(reg_addr_i, `PFC_ADDR_CTRL)) begin
				ctrl_d = reg_wdata_i[11:0];
			end
			if (addr_hit(reg_addr_i, `PFC_ADDR_PRESCALE)) begin
				ps_d = reg_wdata_i[2:0];
			end
			if (addr_hit(reg_addr_i, `PFC_ADDR_CMP_A)) begin
				buf_a_d = reg_wdata_i;
			end
			if (addr_hit(reg_addr_i, `PFC_ADDR_CMP_B)) begin
				buf_b_d = reg_wdata_i;
			end
			if (addr_hit(reg_addr_i, `PFC_ADDR_CAP_TOP)) begin
				cap_d = reg_wdata_i;
			end
			// Write one to clear; a flag set in the same cycle survives.
			if (addr_hit(reg_addr_i, `PFC_ADDR_FLAGS)) begin
				flag_d = (flag_q & ~reg_wdata_i[3:0]) | flag_set;
			end
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`PFC_ADDR_CTRL: rdata_d = {4'h0, ctrl_q};
				`PFC_ADDR_PRESCALE: rdata_d = {13'h0, ps_q};
				`PFC_ADDR_CMP_A: rdata_d = buf_a_q;
				`PFC_ADDR_CMP_B: rdata_d = buf_b_q;
				`PFC_ADDR_CAP_TOP: rdata_d = cap_q;
				`PFC_ADDR_COUNT: rdata_d = cnt_q;
				`PFC_ADDR_FLAGS: rdata_d = {12'h000, flag_q};
				`PFC_ADDR_ACT_A: rdata_d = act_a_q;
				`PFC_ADDR_ACT_B: rdata_d = act_b_q;
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ctrl_q <= 12'h000;
			ps_q <= 3'h0;
			buf_a_q <= 16'h0000;
			buf_b_q <= 16'h0000;
			cap_q <= 16'h0000;
			act_a_q <= 16'h0000;
			act_b_q <= 16'h0000;
			cnt_q <= 16'h0000;
			dir_q <= PFC_UP;
			pre_q <= 10'h000;
			flag_q <= 4'h0;
			rdata_q <= 16'h0000;
		end else begin
			ctrl_q <= ctrl_d;
			ps_q <= ps_d;
			buf_a_q <= buf_a_d;
			buf_b_q <= buf_b_d;
			cap_q <= cap_d;
			act_a_q <= act_a_d;
			act_b_q <= act_b_d;
			cnt_q <= cnt_d;
			dir_q <= dir_d;
			pre_q <= pre_d;
			flag_q <= flag_d;
			rdata_q <= rdata_d;
		end
	end

	assign cmp_a.count = cnt_q;
	assign cmp_a.compare = act_a_q;
	// Zero counts as the rising side and top as the falling side, so both end values stay steady.
	assign cmp_a.up = at_bottom || (dir_q == PFC_UP && !at_top);
	assign cmp_a.tick = tick;
	assign cmp_a.running = running;
	assign cmp_a.out_mode = om_a;
	assign cmp_a.toggle_ok = mode[`PFC_MODE_TOP_BIT];
	assign cmp_a.at_bottom = at_bottom;
	assign cmp_b.count = cnt_q;
	assign cmp_b.compare = act_b_q;
	assign cmp_b.up = at_bottom || (dir_q == PFC_UP && !at_top);
	assign cmp_b.tick = tick;
	assign cmp_b.running = running;
	assign cmp_b.out_mode = om_b;
	assign cmp_b.toggle_ok = 1'b0;
	assign cmp_b.at_bottom = at_bottom;

	pfc_channel u_chan_a (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.cmp(cmp_a.ch)
	);
	pfc_channel u_chan_b (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.cmp(cmp_b.ch)
	);

	logic use_a, use_b;
	assign use_a = (om_a == `PFC_OM_NONINV) || (om_a == `PFC_OM_INV)
		|| ((om_a == `PFC_OM_TOGGLE) && mode[`PFC_MODE_TOP_BIT]);
	assign use_b = (om_b == `PFC_OM_NONINV) || (om_b == `PFC_OM_INV);
	assign wave_out_a_o = (use_a && ctrl_q[`PFC_CTRL_ROUTE_A]) ? cmp_a.wave : port_out_a_i;
	assign wave_out_b_o = (use_b && ctrl_q[`PFC_CTRL_ROUTE_B]) ? cmp_b.wave : port_out_b_i;
	assign pin_oe_n_a_o = !ctrl_q[`PFC_CTRL_DIR_A];
	assign pin_oe_n_b_o = !ctrl_q[`PFC_CTRL_DIR_B];
	assign flags_o = flag_q;
	assign reg_rdata_o = rdata_q;
endmodule : pfc_pwm
`default_nettype wire

// [pfc_pwm_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module pfc_pwm_properties (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic port_out_a_i,
	input wire logic port_out_b_i,
	input wire logic wave_out_a_o,
	input wire logic wave_out_b_o,
	input wire logic pin_oe_n_a_o,
	input wire logic pin_oe_n_b_o,
	input wire logic [3:0] flags_o
);
	logic [11:0] ctl_q;
	logic [2:0] ps_q;
	logic run;
	// The timer only advances in mode 8 or 9 with a prescale code of 1 to 5.
	assign run = ps_q != 3'h0 && ps_q < 3'h6 && ctl_q[3:1] == 3'h4;
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ctl_q <= 12'h000;
			ps_q <= 3'h0;
		end else if (reg_wr_i && reg_addr_i == 4'h0) begin
			ctl_q <= reg_wdata_i[11:0];
		end else if (reg_wr_i && reg_addr_i == 4'h1) begin
			ps_q <= reg_wdata_i[2:0];
		end
	end
	default clocking dc @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	a_rdata_idle: assert property (
		!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("stray read data");
	a_unmapped_zero: assert property (
		reg_rd_i && reg_addr_i > 4'h8 |=> reg_rdata_o == 16'h0000) else $error("unmapped read");
	a_ctrl_readback: assert property (
		reg_rd_i && reg_addr_i == 4'h0 |=> reg_rdata_o[11:0] == ctl_q) else $error("ctrl read");
	a_flag_sticky: assert property (!$past(reg_wr_i && reg_addr_i == 4'h6)
		|-> ($past(flags_o) & ~flags_o) == 4'h0) else $error("flag dropped");
	a_idle_no_flag: assert property (
		(!run) [*3] |-> (flags_o & ~$past(flags_o)) == 4'h0) else $error("flag while idle");
	a_drive_dir: assert property (
		{pin_oe_n_b_o, pin_oe_n_a_o} == ~ctl_q[11:10]) else $error("drive enable");
	a_port_a_mux: assert property (
		!ctl_q[8] || ctl_q[5:4] == 2'h0 || ctl_q[5:4] == 2'h1 && !ctl_q[3]
		|-> wave_out_a_o == port_out_a_i) else $error("port A level");
	a_port_b_mux: assert property (
		!ctl_q[9] || ctl_q[7:6] < 2'h2 |-> wave_out_b_o == port_out_b_i) else $error("port B level");
	c_overflow: cover property ($rose(flags_o[0]));
	c_wave_a: cover property (ctl_q[8] && $rose(wave_out_a_o));
	c_flag_clear: cover property ($fell(flags_o[3]));
endmodule : pfc_pwm_properties
bind pfc_pwm pfc_pwm_properties i_pfc_pwm_properties (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .port_out_a_i(port_out_a_i),
	.port_out_b_i(port_out_b_i), .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o),
	.pin_oe_n_a_o(pin_oe_n_a_o), .pin_oe_n_b_o(pin_oe_n_b_o), .flags_o(flags_o));
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [3:0] adr = 4'h0;
	logic [15:0] wd = 16'h0000;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic pa = 1'b0;
	logic pb = 1'b0;
	logic [15:0] rdat, r, p;
	logic wa, wb, oe_a, oe_b;
	logic [3:0] flags_o;
	int hi_a, hi_b, h;
	int fail_count = 0;
	int num_checks = 0;
	always #2.5 sys_clk_i = ~sys_clk_i;
	pfc_pwm i_pfc_pwm (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(adr),
		.reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdat),
		.port_out_a_i(pa), .port_out_b_i(pb), .wave_out_a_o(wa), .wave_out_b_o(wb),
		.pin_oe_n_a_o(oe_a), .pin_oe_n_b_o(oe_b), .flags_o(flags_o));
	pfc_load_model i_load_a (.sys_clk_i(sys_clk_i), .wave_i(wa), .oe_n_i(oe_a), .high_count_o(hi_a));
	pfc_load_model i_load_b (.sys_clk_i(sys_clk_i), .wave_i(wb), .oe_n_i(oe_b), .high_count_o(hi_b));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		adr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge sys_clk_i);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk_i);
		adr <= a;
		rd_s <= 1'b1;
		@(posedge sys_clk_i);
		rd_s <= 1'b0;
		#1 r = rdat;
	endtask : rd
	task automatic t_count;
		logic [15:0] pp;
		int n[4] = '{8, 64, 256, 1024};
		wr(4'h4, 16'h0003);
		wr(4'h0, 16'h0008);
		wr(4'h1, 16'h0001);
		@(posedge sys_clk_i);
		adr <= 4'h5;
		rd_s <= 1'b1;
		@(posedge sys_clk_i);
		#1 pp = rdat;
		@(posedge sys_clk_i);
		#1 p = rdat;
		repeat (12) begin
			@(posedge sys_clk_i);
			#1 r = rdat;
			chk(r, p == 16'h3 ? 16'h2 : p == 16'h0 ? 16'h1 : p > pp ? p + 16'h1 : p - 16'h1);
			pp = p;
			p = r;
		end
		rd_s <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr(4'h1, 16'(i + 2));
			rd(4'h5);
			p = r;
			repeat (n[i] - 2) @(posedge sys_clk_i);
			rd(4'h5);
			chk(r > p ? r - p : p - r, 16'h1);
		end
		wr(4'h0, 16'h0000);
		rd(4'h5);
		p = r;
		rd(4'h5);
		chk(r, p);
		$display("count test done");
	endtask : t_count
	task automatic t_duty;
		wr(4'h1, 16'h0001);
		for (int m = 2; m < 4; m++) begin
			for (int c = 0; c < 4; c++) begin
				wr(4'h0, 16'h0508 | 16'(m << 4));
				wr(4'h2, 16'(c));
				repeat (20) @(posedge sys_clk_i);
				h = hi_a;
				repeat (12) @(posedge sys_clk_i);
				chk(16'(hi_a - h), 16'(m == 2 ? 4 * c : 12 - 4 * c));
			end
		end
		wr(4'h0, 16'h0518);
		repeat (20) @(posedge sys_clk_i);
		h = hi_a;
		repeat (12) @(posedge sys_clk_i);
		chk(16'(hi_a - h), 16'h6);
		wr(4'h0, 16'h0128);
		#1 chk(oe_a, 1'b1);
		pa <= 1'b1;
		wr(4'h0, 16'h0428);
		#1 chk(wa, 1'b1);
		$display("duty test done");
	endtask : t_duty
	task automatic t_flags;
		pa <= 1'b0;
		wr(4'h3, 16'h0001);
		wr(4'h0, 16'h0A89);
		repeat (30) @(posedge sys_clk_i);
		wr(4'h6, 16'h000F);
		h = hi_b;
		repeat (12) @(posedge sys_clk_i);
		chk(16'(hi_b - h), 16'h4);
		chk(flags_o, 4'h7);
		wr(4'h2, 16'h0001);
		wr(4'h3, 16'h0005);
		wr(4'h0, 16'h0008);
		repeat (30) @(posedge sys_clk_i);
		wr(4'h6, 16'h000F);
		repeat (12) @(posedge sys_clk_i);
		chk(flags_o, 4'hB);
		$display("flag test done");
	endtask : t_flags
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		chk(oe_a, 1'b1);
		rd(4'hF);
		chk(r, 16'h0000);
		t_count();
		t_duty();
		t_flags();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
